/* File: verilog/psh_pkg.sv */
// Operation
// R01: select bits form code, bit2 most significant
// R02: no select assigned uses target zero
// R03: accept code only after settle delay
// R04: configuration picks homing variant and direction
// R05: homing completion clears position counter
// R06: without homing, power-on position is origin
// R07: low-speed homing stops at limit assert
// R08: high-speed homing reverses, stops at deassert
// R09: changeover on speed, off position control
// R10: changeover off references position at instant
// R11: target zero at switch stops motor there
// R12: speed mode direction follows run command
// R13: controller holds select beyond settle delay
package psh_pkg;
  localparam int unsigned POS_W        = 32;
  localparam int unsigned SEL_W        = 3;
  localparam int unsigned SETTLE_W     = 16;
  localparam logic [SEL_W-1:0] SEL_RESET = 3'h0;
  localparam logic [POS_W-1:0] POS_ZERO  = 32'h0000_0000;
  // homing variant codes
  localparam logic [1:0] HOME_LOW  = 2'h0;
  localparam logic [1:0] HOME_HIGH = 2'h1;
  localparam logic [1:0] HOME_ALT  = 2'h2;
  // speed command codes on home_speed
  localparam logic [1:0] SPD_STOP = 2'h0;
  localparam logic [1:0] SPD_LOW  = 2'h1;
  localparam logic [1:0] SPD_HIGH = 2'h2;
  typedef enum logic [2:0] {
    PSH_IDLE  = 3'h0,
    PSH_RUN   = 3'h1,
    PSH_DECEL = 3'h2,
    PSH_REV   = 3'h3,
    PSH_FINAL = 3'h4
  } psh_home_state_t;
endpackage

/* File: verilog/psh_position_select_homing.sv */
module psh_position_select_homing (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 nrst,
  // select terminals and assignment
  input  wire logic                 pos_select_bit0,
  input  wire logic                 pos_select_bit1,
  input  wire logic                 pos_select_bit2,
  input  wire logic                 select_assigned,
  input  wire logic [15:0]          settle_cycles,
  input  wire logic [8*32-1:0]      stored_target_positions,
  // homing control
  input  wire logic                 origin_limit_in,
  input  wire logic                 home_start,
  input  wire logic [1:0]           homing_variant_setting,
  input  wire logic                 homing_direction_setting,
  input  wire logic                 decel_done,
  input  wire logic                 final_pos_done,
  // motion feedback and changeover
  input  wire logic                 speed_position_changeover,
  input  wire logic                 run_dir_cmd,
  input  wire logic                 pos_step,
  input  wire logic                 pos_step_dir,
  // outputs
  output logic [31:0]               target_position,
  output logic [2:0]                active_select,
  output logic [31:0]               position_count,
  output logic                      position_mode,
  output logic                      hold_here,
  output logic                      homing_busy,
  output logic                      homing_done,
  output logic                      home_dir,
  output logic [1:0]                home_speed,
  output logic                      final_positioning,
  output logic                      motor_dir
);
  // two-flop synchronisers for terminal pins
  logic [4:0] sync1;
  logic [4:0] sync2;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
    end else begin
      sync1 <= {speed_position_changeover, origin_limit_in, pos_select_bit2, pos_select_bit1, pos_select_bit0};
      sync2 <= sync1;
    end
  end

  logic [2:0] sel_raw;
  logic       limit_s;
  logic       spd_s;
  assign sel_raw = sync2[2:0]; // bit2 is msb [R01]
  assign limit_s = sync2[3];
  assign spd_s   = sync2[4];

  function automatic logic [31:0] pick_pos(input logic [8*32-1:0] tbl, input logic [2:0] idx);
    pick_pos = tbl[idx*32 +: 32];
  endfunction

  // settle filter: code must stay unchanged for settle_cycles
  logic [2:0]  sel_seen;
  logic [15:0] settle_cnt;
  logic [2:0]  sel_code;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sel_seen   <= psh_pkg::SEL_RESET;
      settle_cnt <= 16'h0000;
      sel_code   <= psh_pkg::SEL_RESET;
    end else if (sel_raw != sel_seen) begin
      sel_seen   <= sel_raw; // fluctuation restarts the wait [R03]
      settle_cnt <= 16'h0000;
    end else if (settle_cnt >= settle_cycles) begin
      sel_code   <= sel_seen; // stable long enough [R03]
    end else begin
      settle_cnt <= settle_cnt + 16'h0001;
    end
  end

  // unassigned selects force code zero
  logic [2:0] eff_code;
  assign eff_code = select_assigned ? sel_code : 3'h0; // [R02]
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      active_select   <= psh_pkg::SEL_RESET;
      target_position <= psh_pkg::POS_ZERO;
    end else begin
      active_select   <= eff_code;
      target_position <= pick_pos(stored_target_positions, eff_code); // [R01]
    end
  end

  // homing sequencer
  psh_pkg::psh_home_state_t st;
  logic                     hvar;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st          <= psh_pkg::PSH_IDLE;
      hvar        <= 1'b0;
      home_dir    <= 1'b0;
      homing_done <= 1'b0;
    end else begin
      homing_done <= 1'b0;
      case (st)
        psh_pkg::PSH_IDLE: begin
          if (home_start) begin
            hvar     <= (homing_variant_setting == psh_pkg::HOME_HIGH); // [R04]
            home_dir <= homing_direction_setting; // [R04]
            st       <= psh_pkg::PSH_RUN;
          end
        end
        psh_pkg::PSH_RUN: begin
          if (limit_s) begin
            st <= hvar ? psh_pkg::PSH_DECEL : psh_pkg::PSH_FINAL; // [R07] [R08]
          end
        end
        psh_pkg::PSH_DECEL: begin
          if (decel_done) begin
            home_dir <= ~home_dir; // reverse at low speed [R08]
            st       <= psh_pkg::PSH_REV;
          end
        end
        psh_pkg::PSH_REV: begin
          if (!limit_s) begin
            st <= psh_pkg::PSH_FINAL; // [R08]
          end
        end
        psh_pkg::PSH_FINAL: begin
          if (final_pos_done) begin
            homing_done <= 1'b1;
            st          <= psh_pkg::PSH_IDLE;
          end
        end
        default: st <= psh_pkg::PSH_IDLE;
      endcase
    end
  end

  // speed request and status per state
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      home_speed        <= psh_pkg::SPD_STOP;
      homing_busy       <= 1'b0;
      final_positioning <= 1'b0;
    end else begin
      homing_busy       <= (st != psh_pkg::PSH_IDLE);
      final_positioning <= (st == psh_pkg::PSH_FINAL);
      case (st)
        psh_pkg::PSH_RUN:  home_speed <= hvar ? psh_pkg::SPD_HIGH : psh_pkg::SPD_LOW; // [R07] [R08]
        psh_pkg::PSH_REV:  home_speed <= psh_pkg::SPD_LOW; // [R08]
        default:           home_speed <= psh_pkg::SPD_STOP;
      endcase
    end
  end

  // position counter: zero at reset is the power-on origin
  logic spd_d;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      position_count <= psh_pkg::POS_ZERO; // power-on position as origin [R06]
      spd_d          <= 1'b0;
    end else begin
      spd_d <= spd_s;
      if (homing_done) begin
        position_count <= psh_pkg::POS_ZERO; // [R05]
      end else if (spd_s) begin
        position_count <= psh_pkg::POS_ZERO; // count forced to zero every cycle while speed mode [R10]
      end else if (pos_step) begin
        position_count <= pos_step_dir ? position_count - 32'h1 : position_count + 32'h1;
      end
    end
  end

  // mode and direction; hold flag when switching with target zero
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      position_mode <= 1'b1;
      hold_here     <= 1'b0;
      motor_dir     <= 1'b0;
    end else begin
      position_mode <= ~spd_s; // [R09]
      if (spd_s) begin
        hold_here <= 1'b0;
      end else if (spd_d && (target_position == psh_pkg::POS_ZERO)) begin
        hold_here <= 1'b1; // stop at switch point [R10] [R11]
      end
      if (homing_busy) begin
        motor_dir <= home_dir;
      end else if (spd_s) begin
        motor_dir <= run_dir_cmd; // [R12]
      end else begin
        motor_dir <= target_position[31] ^ position_count[31] ? target_position[31] : 1'b0;
      end
    end
  end
endmodule

/* File: sim/psh_ctrl_model.sv */
module psh_ctrl_model (
  // requests from the bench
  input  wire logic       core_clk,
  input  wire logic [2:0] code,
  input  wire logic       limit,
  // terminals into the drive
  output logic            pos_select_bit0, pos_select_bit1, pos_select_bit2, origin_limit_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {pos_select_bit2, pos_select_bit1, pos_select_bit0, origin_limit_in} = 4'h0;
  // pins lag the request by one cycle, like a slow plc output card
  always @(negedge core_clk) begin
    {pos_select_bit2, pos_select_bit1, pos_select_bit0} <= code;
    origin_limit_in <= limit;
  end
endmodule

/* File: sim/psh_position_select_homing_chk.sv */
module psh_chk (
  // one clock domain; ports of the block packed per group to stay small
  input wire logic         core_clk, nrst, select_assigned, speed_position_changeover, run_dir_cmd,
  input wire logic         pos_select_bit0, pos_select_bit1, pos_select_bit2, homing_direction_setting,
  input wire logic [255:0] stored_target_positions,
  input wire logic [1:0]   homing_variant_setting, home_speed,
  input wire logic [31:0]  target_position, position_count,
  input wire logic [2:0]   active_select,
  input wire logic         position_mode, hold_here, homing_busy, homing_done, home_dir
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // code seen on the pins three cycles back is what gets taken
  a_code_taken: assert property ($changed(active_select) && select_assigned
    |-> active_select == $past({pos_select_bit2, pos_select_bit1, pos_select_bit0}, 3)) else $error("code");
  a_unassigned_zero: assert property ($changed(active_select) && !select_assigned |-> active_select == 3'h0)
    else $error("unassigned");
  a_target_slot: assert property ($changed(active_select)
    |-> target_position == stored_target_positions[active_select*32 +: 32]) else $error("target");
  a_home_clears: assert property (homing_done |=> position_count == 32'h0) else $error("clear");
  a_low_no_high: assert property (homing_busy && homing_variant_setting != psh_pkg::HOME_HIGH
    |-> home_speed != psh_pkg::SPD_HIGH) else $error("low speed");
  a_speed_held: assert property (speed_position_changeover [*4]
    |-> position_count == 32'h0 && !position_mode) else $error("speed mode");
  a_pos_mode: assert property (!speed_position_changeover [*4] |-> position_mode) else $error("pos mode");
  a_hold_zero: assert property ($rose(position_mode) && target_position == 32'h0 |-> ##[0:2] hold_here)
    else $error("hold");
  a_home_dir: assert property ($rose(homing_busy) |-> ##[0:1] home_dir == homing_direction_setting)
    else $error("home dir");
  c_high_done: cover property (homing_done && homing_variant_setting == psh_pkg::HOME_HIGH);
  c_hold: cover property ($rose(hold_here));
  c_top_code: cover property (active_select == 3'h7);
endmodule
bind psh_position_select_homing psh_chk chk (.*);

/* File: sim/psh_position_select_homing_bench.sv */
module psh_position_select_homing_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // stimulus and observed ports, named as the block's pins
  logic         core_clk = 1'b0, nrst = 1'b0, select_assigned = 1'b1, home_start = 1'b0, limit = 1'b0;
  logic         decel_done = 1'b0, final_pos_done = 1'b0, speed_position_changeover = 1'b0, run_dir_cmd = 1'b0;
  logic         pos_step = 1'b0, pos_step_dir = 1'b0, homing_direction_setting = 1'b0;
  logic [15:0]  settle_cycles = 16'h0004;
  logic [255:0] stored_target_positions = '0;
  logic [1:0]   homing_variant_setting = 2'h0, home_speed;
  logic [2:0]   code = 3'h0, active_select;
  logic [31:0]  target_position, position_count;
  logic         pos_select_bit0, pos_select_bit1, pos_select_bit2, origin_limit_in, position_mode, hold_here;
  logic         homing_busy, homing_done, home_dir, final_positioning, motor_dir;
  int           fail_count = 0, samples_checked = 0, i, n;
  always #4 core_clk = ~core_clk;
  psh_position_select_homing uut (.*);
  psh_ctrl_model ctl (.*);
  function logic [31:0] exp_t(input logic [2:0] c);
    return stored_target_positions[c*32 +: 32];
  endfunction
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task results;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task tick(input int c);
    repeat (c) @(negedge core_clk);
  endtask
  // bounded wait: 0 busy, 1 final positioning, 2 done
  task wait_k(input int k);
    // look before stepping: the done flag stands for one cycle only
    for (i = 0; i < 400; i++) begin
      if (k == 0 ? homing_busy === 1'b1 : k == 1 ? final_positioning === 1'b1 : homing_done === 1'b1) break;
      tick(1);
    end
    if (i == 400) begin
      fail_count++;
      results();
    end
  endtask
  initial begin
    n = $urandom(15);
    // slot 0 kept at zero so the stop-on-switch case is reachable
    for (n = 1; n < 8; n++) stored_target_positions[n*32 +: 32] = $urandom;
    tick(5);
    nrst = 1'b1;
    // every code, then random ones, each followed by a glitch shorter than the settle time
    for (n = 0; n < 12; n++) begin
      code <= (n < 8) ? n[2:0] : 3'($urandom);
      tick(14);
      code <= ~code;
      tick(3);
      code <= ~code;
      tick(5);
      check("active_select", {29'h0, active_select}, {29'h0, code});
      check("target_position", target_position, exp_t(code));
    end
    select_assigned <= 1'b0;
    code <= 3'h5;
    tick(14);
    check("unassigned target", target_position, exp_t(3'h0));
    select_assigned <= 1'b1;
    code <= 3'h0;
    $display("select test done");
    for (n = 0; n < 3; n++) begin
      pos_step <= ~pos_step;
      tick(1);
    end
    pos_step <= 1'b0; // two one-cycle steps only
    tick(4);
    check("count from power-on origin", position_count, 32'h2);
    // every homing variant, random direction
    for (n = 0; n < 3; n++) begin
      homing_variant_setting <= n[1:0];
      homing_direction_setting <= 1'($urandom);
      home_start <= 1'b1;
      tick(1);
      home_start <= 1'b0;
      wait_k(0);
      tick(2);
      check("home_dir", {31'h0, home_dir}, {31'h0, homing_direction_setting});
      check("home_speed", {30'h0, home_speed}, n == 1 ? 32'h2 : 32'h1);
      limit <= 1'b1;
      if (n == 1) begin
        tick(8);
        decel_done <= 1'b1;
        tick(1);
        decel_done <= 1'b0;
        tick(4);
        check("reverse dir", {31'h0, home_dir}, {31'h0, ~homing_direction_setting});
        check("reverse speed", {30'h0, home_speed}, 32'h1);
        limit <= 1'b0;
      end
      wait_k(1);
      final_pos_done <= 1'b1;
      tick(1);
      final_pos_done <= 1'b0;
      wait_k(2);
      tick(1);
      check("count after homing", position_count, 32'h0);
      limit <= 1'b0;
      tick(4);
    end
    $display("homing test done");
    // speed mode: count stays zero while steps arrive, direction from run command
    speed_position_changeover <= 1'b1;
    run_dir_cmd <= 1'($urandom);
    pos_step <= 1'b1;
    tick(8);
    check("speed mode", {31'h0, position_mode}, 32'h0);
    check("count in speed mode", position_count, 32'h0);
    check("motor_dir", {31'h0, motor_dir}, {31'h0, run_dir_cmd});
    speed_position_changeover <= 1'b0;
    pos_step <= 1'b0;
    tick(6);
    check("position mode", {31'h0, position_mode}, 32'h1);
    check("hold_here", {31'h0, hold_here}, 32'h1);
    $display("changeover test done");
    results();
  end
endmodule
